// file: verilog/dma_chan_pkg.sv
// Constants, register map and carrier types for one DMA channel.
// Assumes an APB slave port and a simple single-beat memory master port.
package dma_chan_pkg;
    // Register indices; byte address is four times the index
    localparam logic [31:0] SRC_IDX = 32'h5000_3610;
    localparam logic [31:0] DST_IDX = 32'h5000_3614;
    localparam logic [31:0] THR_IDX = 32'h5000_3618;
    localparam logic [31:0] LEN_IDX = 32'h5000_361A;
    localparam logic [31:0] CTRL_IDX = 32'h5000_361C;
    localparam logic [31:0] ITEM_IDX = 32'h5000_361E;
    localparam logic [31:0] STAT_IDX = 32'h5000_3640;
    localparam logic [31:0] MASK_IDX = 32'h5000_3641;
    // Reset values
    localparam logic [15:0] LEN_RST = 16'h0000;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] THR_RST = 16'h0000;
    localparam logic [1:0] EVT_RST = 2'h0;
    // Event bit positions in status and mask
    localparam int EVT_THR = 0;
    localparam int EVT_DONE = 1;
    // Item width codes
    localparam logic [1:0] W_BYTE = 2'h0;
    localparam logic [1:0] W_HALF = 2'h1;
    localparam logic [1:0] W_WORD = 2'h2;

    // Control register layout, bit 15 down to bit 0
    typedef struct packed {
        logic [1:0] rsv;
        logic edge_sense;
        logic fill;
        logic yield;
        logic [2:0] channel_priority;
        logic circular;
        logic source_step_enable;
        logic dest_step_enable;
        logic request_trigger_mode;
        logic irq_en;
        logic [1:0] item_width;
        logic on;
    } ctrl_t;

    // Memory bus request issued by the channel
    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    // Arbitration view of one channel
    typedef struct packed {
        logic req;
        logic [2:0] prio;
    } arb_t;

    typedef enum logic [2:0] {
        S_IDLE, S_WAIT, S_ARB, S_READ, S_WRITE, S_GAP
    } state_t;
endpackage : dma_chan_pkg

// file: verilog/dma_channel_control.sv
// One DMA channel (channel_one): APB registers, trigger sensing, arbitration
// against channel_zero, and a single-beat memory master.
// Assumes mem_ack pulses for one cycle per accepted beat, and that
// channel_zero presents its request and priority on the same clock.
module dma_channel_control
    import dma_chan_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Memory master
    output dma_chan_pkg::mem_req_t mem_req,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // Arbitration with channel_zero
    input dma_chan_pkg::arb_t zero_arb,
    output dma_chan_pkg::arb_t one_arb,
    output logic bus_lock,
    // Peripheral request and interrupt
    input wire logic periph_req,
    output logic irq
);
    import dma_chan_pkg::*;

    // ***********************************
    // Registers and state
    // ***********************************
    ctrl_t ctrl_q;
    logic [15:0] len_q;
    logic [15:0] thr_q;
    logic [31:0] src_q;
    logic [31:0] dst_q;
    logic [15:0] idx_q;
    logic [1:0] stat_q;
    logic [1:0] mask_q;
    state_t state_q;
    logic [31:0] data_q;
    logic fill_held_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    mem_req_t mem_req_q;
    arb_t one_arb_q;
    logic bus_lock_q;
    logic irq_q;
    // Synchroniser chain for the peripheral request pin
    logic preq_s1_q;
    logic preq_s2_q;
    logic preq_s3_q;
    logic pend_q;

    // ***********************************
    // APB decode
    // ***********************************
    logic acc;
    logic wr;
    logic hit_src, hit_dst, hit_thr, hit_len, hit_ctrl, hit_item, hit_stat, hit_mask;
    logic mapped;

    // Unmapped addresses still complete; pslverr marks them and writes are dropped
    assign acc = psel && penable && pready_q;
    assign wr = acc && pwrite;
    assign hit_src = paddr == {SRC_IDX[29:0], 2'h0};
    assign hit_dst = paddr == {DST_IDX[29:0], 2'h0};
    assign hit_thr = paddr == {THR_IDX[29:0], 2'h0};
    assign hit_len = paddr == {LEN_IDX[29:0], 2'h0};
    assign hit_ctrl = paddr == {CTRL_IDX[29:0], 2'h0};
    assign hit_item = paddr == {ITEM_IDX[29:0], 2'h0};
    assign hit_stat = paddr == {STAT_IDX[29:0], 2'h0};
    assign hit_mask = paddr == {MASK_IDX[29:0], 2'h0};
    assign mapped = hit_src | hit_dst | hit_thr | hit_len | hit_ctrl | hit_item
                  | hit_stat | hit_mask;

    // One wait state: ready rises in the first access cycle's next edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
            prdata_q <= 32'h0000_0000;
            if (psel && penable && !pready_q && !pwrite) begin
                unique0 case (1'b1)
                    hit_src: prdata_q <= src_q;
                    hit_dst: prdata_q <= dst_q;
                    hit_thr: prdata_q <= {16'h0000, thr_q};
                    hit_len: prdata_q <= {16'h0000, len_q};
                    hit_ctrl: prdata_q <= {16'h0000, 2'h0, ctrl_q[13:0]};
                    hit_item: prdata_q <= {16'h0000, idx_q};
                    hit_stat: prdata_q <= {30'h0000_0000, stat_q};
                    hit_mask: prdata_q <= {30'h0000_0000, mask_q};
                endcase
            end
        end
    end

    // ***********************************
    // Peripheral request sensing
    // ***********************************
    logic preq_hit;
    logic trig_mode;
    logic yield_eff;
    logic last_item;
    logic step_done;

    // Two flops tame metastability; the third only remembers the level for edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            preq_s1_q <= 1'b0;
            preq_s2_q <= 1'b0;
            preq_s3_q <= 1'b0;
        end else begin
            preq_s1_q <= periph_req;
            preq_s2_q <= preq_s1_q;
            preq_s3_q <= preq_s2_q;
        end
    end

    // Edge mode latches the rising edge so a short pulse is not missed
    // Level mode re-checks the request before every item
    assign preq_hit = ctrl_q.edge_sense ? (preq_s2_q && !preq_s3_q) : preq_s2_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 1'b0;
        end else if (!ctrl_q.on || !ctrl_q.edge_sense) begin
            pend_q <= 1'b0;
        end else if (state_q == S_WAIT) begin
            // An edge seen while waiting is taken at once, so one edge moves one item
            pend_q <= 1'b0;
        end else if (preq_s2_q && !preq_s3_q) begin
            pend_q <= 1'b1;
        end
    end

    assign trig_mode = ctrl_q.request_trigger_mode;
    assign yield_eff = ctrl_q.yield && !trig_mode;
    assign last_item = idx_q == len_q;
    assign step_done = state_q == S_WRITE && mem_ack;

    // ***********************************
    // Control, length and address registers
    // ***********************************
    logic done_evt;
    logic thr_evt;
    logic stays_on;

    assign stays_on = ctrl_q.circular && trig_mode;
    assign done_evt = step_done && last_item;
    // Threshold compares the index of the item just stored, before it advances
    assign thr_evt = step_done && ctrl_q.irq_en && idx_q == thr_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            len_q <= LEN_RST;
            thr_q <= THR_RST;
            src_q <= 32'h0000_0000;
            dst_q <= 32'h0000_0000;
            mask_q <= EVT_RST;
        end else begin
            // Control writes while busy update fields without restarting the engine
            if (wr && hit_ctrl) begin
                ctrl_q <= {2'h0, pwdata[13:0]};
            end else if (done_evt && !stays_on) begin
                ctrl_q.on <= 1'b0;
            end
            if (wr && hit_len) begin
                len_q <= pwdata[15:0];
            end
            if (wr && hit_thr) begin
                thr_q <= pwdata[15:0];
            end
            if (wr && hit_src) begin
                src_q <= pwdata;
            end
            if (wr && hit_dst) begin
                dst_q <= pwdata;
            end
            if (wr && hit_mask) begin
                mask_q <= pwdata[1:0];
            end
        end
    end

    // ***********************************
    // Interrupt status, mask and output
    // ***********************************
    // A new event in the clearing cycle stays set
    // Events are recorded only while interrupts are enabled on this channel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= EVT_RST;
            irq_q <= 1'b0;
        end else begin
            stat_q[EVT_THR] <= thr_evt || (stat_q[EVT_THR] && !(wr && hit_stat
                               && pwdata[EVT_THR]));
            stat_q[EVT_DONE] <= (done_evt && ctrl_q.irq_en) || (stat_q[EVT_DONE]
                                && !(wr && hit_stat && pwdata[EVT_DONE]));
            irq_q <= ctrl_q.irq_en && |(stat_q & mask_q);
        end
    end

    // ***********************************
    // Transfer engine
    // ***********************************
    logic win;
    logic [31:0] offs;
    logic start;
    logic [31:0] step;

    // Channel zero wins ties since it has the lower number
    assign win = !zero_arb.req || ctrl_q.channel_priority > zero_arb.prio;
    // Reserved width code 11 steps like a word
    assign offs = ctrl_q.item_width == W_BYTE ? {16'h0000, idx_q}
                : ctrl_q.item_width == W_HALF ? {15'h0000, idx_q, 1'b0}
                : {14'h0000, idx_q, 2'h0};
    assign start = wr && hit_ctrl && pwdata[0] && state_q == S_IDLE;
    // One item's address step; reserved code 11 steps like a word
    assign step = ctrl_q.item_width == W_BYTE ? 32'h0000_0001
                : ctrl_q.item_width == W_HALF ? 32'h0000_0002
                : 32'h0000_0004;

    // Addresses come from the start registers plus the scaled index, never accumulated
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            idx_q <= 16'h0000;
            data_q <= 32'h0000_0000;
            fill_held_q <= 1'b0;
            mem_req_q <= '0;
        end else if (!ctrl_q.on && state_q != S_IDLE) begin
            // Software switched the channel off mid-transfer
            state_q <= S_IDLE;
            idx_q <= 16'h0000;
            fill_held_q <= 1'b0;
            mem_req_q <= '0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (start) begin
                        idx_q <= 16'h0000;
                        state_q <= pwdata[4] ? S_WAIT : S_ARB;
                    end
                end
                S_WAIT: begin
                    if (preq_hit || pend_q) begin
                        state_q <= S_ARB;
                    end
                end
                S_ARB: begin
                    // A fill transfer already under way is never pre-empted
                    if (win || fill_held_q) begin
                        if (ctrl_q.fill && fill_held_q) begin
                            state_q <= S_WRITE;
                            mem_req_q.write <= 1'b1;
                            mem_req_q.addr <= dst_q + (ctrl_q.dest_step_enable ? offs
                                              : 32'h0000_0000);
                            mem_req_q.wdata <= data_q;
                        end else begin
                            state_q <= S_READ;
                            mem_req_q.write <= 1'b0;
                            mem_req_q.addr <= src_q + (ctrl_q.source_step_enable ? offs
                                              : 32'h0000_0000);
                        end
                        mem_req_q.valid <= 1'b1;
                        mem_req_q.size <= ctrl_q.item_width;
                    end
                end
                S_READ: begin
                    if (mem_ack) begin
                        data_q <= mem_rdata;
                        fill_held_q <= ctrl_q.fill;
                        state_q <= S_WRITE;
                        mem_req_q.write <= 1'b1;
                        mem_req_q.addr <= dst_q + (ctrl_q.dest_step_enable ? offs
                                          : 32'h0000_0000);
                        // The fetched word goes straight out as store data
                        mem_req_q.wdata <= mem_rdata;
                    end
                end
                S_WRITE: begin
                    if (mem_ack) begin
                        mem_req_q.valid <= 1'b0;
                        if (last_item) begin
                            // Index returns to zero at completion, in circular mode too
                            idx_q <= 16'h0000;
                            fill_held_q <= 1'b0;
                            state_q <= stays_on ? S_WAIT : S_IDLE;
                        end else begin
                            idx_q <= idx_q + 16'h0001;
                            if (trig_mode) begin
                                state_q <= S_WAIT;
                            end else if (yield_eff) begin
                                state_q <= S_GAP;
                            end else if (ctrl_q.fill) begin
                                // Fill keeps the bus: no re-arbitration
                                state_q <= S_WRITE;
                                mem_req_q.valid <= 1'b1;
                                // Store data is reused from the single fetch
                                mem_req_q.addr <= dst_q + (ctrl_q.dest_step_enable
                                                  ? offs + step
                                                  : 32'h0000_0000);
                            end else begin
                                state_q <= S_ARB;
                            end
                        end
                    end
                end
                S_GAP: begin
                    // One idle bus cycle lets the processor or cache in, unless a fill transfer already holds bus_lock
                    state_q <= S_ARB;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ***********************************
    // Arbitration outputs
    // ***********************************
    // Lock covers blocking copies, and with yield set outside trigger mode covers fill transfers only once the fetch has been acknowledged
    // The request is registered: channel_zero sees it a cycle after arbitration starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            one_arb_q <= '0;
            bus_lock_q <= 1'b0;
        end else begin
            one_arb_q.req <= state_q == S_ARB;
            one_arb_q.prio <= ctrl_q.channel_priority;
            bus_lock_q <= ctrl_q.on && state_q != S_IDLE && state_q != S_WAIT
                          && (!yield_eff || (ctrl_q.fill && fill_held_q));
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign mem_req = mem_req_q;
    assign one_arb = one_arb_q;
    assign bus_lock = bus_lock_q;
    assign irq = irq_q;
endmodule : dma_channel_control

// file: tb/dma_channel_chk.sv
// Checker for one DMA channel; sees only the top module's ports.
// Assumes control fields change only through APB writes.
module dma_channel_chk
    import dma_chan_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Memory and arbitration
    input dma_chan_pkg::mem_req_t mem_req,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    input dma_chan_pkg::arb_t zero_arb,
    input dma_chan_pkg::arb_t one_arb,
    input wire logic bus_lock,
    input wire logic irq
);
    // ****************************************
    // Shadow of software fields
    // ****************************************
    ctrl_t c_q;
    logic [31:0] rd_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c_q <= '0;
        end else if (psel && penable && pready && pwrite && paddr == {CTRL_IDX[29:0], 2'b00}) begin
            c_q <= ctrl_t'(pwdata[15:0]);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_q <= '0;
        end else if (mem_ack && mem_req.valid && !mem_req.write) begin
            rd_q <= mem_rdata;
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_pending;
        mem_req.valid && !mem_ack;
    endsequence
    chk_ready_delay: assert property (s_setup |-> ##2 pready)
        else $error("pready not two cycles after setup");
    chk_req_hold: assert property (s_pending |=> $stable(mem_req))
        else $error("memory request changed before ack");
    chk_copy_data: assert property (mem_req.valid && mem_req.write |-> mem_req.wdata == rd_q)
        else $error("store data differs from fetched item");
    chk_item_size: assert property (mem_req.valid |-> mem_req.size == c_q.item_width)
        else $error("beat size differs from item width");
    chk_irq_gate: assert property (!c_q.irq_en |=> !irq)
        else $error("interrupt while disabled");
    chk_prio_view: assert property (one_arb.req |-> one_arb.prio == c_q.channel_priority)
        else $error("arbitration priority differs from control");
    chk_equal_loses: assert property (one_arb.req && zero_arb.req && zero_arb.prio >= one_arb.prio
        |=> !mem_req.valid)
        else $error("channel won without higher priority");
    chk_block_lock: assert property (mem_req.valid && $past(mem_req.valid) && !c_q.yield
        && !c_q.request_trigger_mode |-> bus_lock)
        else $error("blocking transfer left bus open");
endmodule : dma_channel_chk

// file: tb/dma_mem_model.sv
// Memory model on the channel's master port: acks each beat, logs addresses.
// Assumes the channel holds mem_req until it has seen mem_ack.
module dma_mem_model
    import dma_chan_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Channel bus
    input dma_chan_pkg::mem_req_t mem_req,
    input wire logic slow,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] rd_a [64];
    logic [31:0] wr_a [64];
    logic [31:0] wr_d [64];
    int rd_n = 0;
    int wr_n = 0;
    int cnt = 0;
    function automatic logic [31:0] pat(input logic [31:0] a);
        return a ^ 32'hC3A5_5A3C;
    endfunction : pat
    // Outside a read ack the read data toggles, so stale data never looks fresh
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req.valid && !mem_ack) begin
                if (cnt < (slow ? 3 : 0)) begin
                    cnt++;
                end else begin
                    cnt = 0;
                    mem_ack <= 1'b1;
                    if (mem_req.write) begin
                        wr_a[wr_n] = mem_req.addr;
                        wr_d[wr_n] = mem_req.wdata;
                        wr_n++;
                    end else begin
                        mem_rdata <= pat(mem_req.addr);
                        rd_a[rd_n] = mem_req.addr;
                        rd_n++;
                    end
                end
            end
        end
    end
endmodule : dma_mem_model

// file: tb/tb.sv
// Testbench top: APB tasks program the channel, the memory model answers.
// Assumes channel_zero is stood in for by the zero_arb signals driven here.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dma_chan_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    mem_req_t mem_req;
    logic mem_ack;
    logic [31:0] mem_rdata;
    arb_t zero_arb = '0;
    arb_t one_arb;
    logic bus_lock;
    logic periph_req = 1'b0;
    logic irq;
    logic slow = 1'b0;
    int errors = 0;
    int checked = 0;
    int n0;
    int m0;
    logic [31:0] q;
    logic e;
    ctrl_t c;
    always #2 pclk = ~pclk;
    dma_channel_control DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .mem_req, .mem_ack, .mem_rdata, .zero_arb, .one_arb,
        .bus_lock, .periph_req, .irq);
    dma_mem_model mem (.pclk, .presetn, .mem_req, .slow, .mem_ack, .mem_rdata);
    // ****************************************
    // Tasks
    // ****************************************
    task automatic report_and_stop();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [31:0] i, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i[29:0], 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 40) chk("apb answer", 1, 0);
    endtask : apb
    task automatic rc(input string nm, input logic [31:0] i, input logic [31:0] x);
        apb(1'b0, i, 0);
        chk(nm, x, q);
    endtask : rc
    task automatic setup(input logic [15:0] len);
        apb(1'b1, SRC_IDX, 32'h1000);
        apb(1'b1, DST_IDX, 32'h2000);
        apb(1'b1, LEN_IDX, {16'h0, len});
        n0 = mem.wr_n;
        m0 = mem.rd_n;
    endtask : setup
    // Polls the on bit; the write is skipped when w is clear, as for a channel already armed
    task automatic go(input ctrl_t v, input bit w);
        int k;
        k = 0;
        if (w) apb(1'b1, CTRL_IDX, {16'h0, v});
        do begin
            apb(1'b0, CTRL_IDX, 0);
            k++;
        end while (q[0] !== 1'b0 && k < 200);
        chk("on cleared", 0, q[0]);
    endtask : go
    task automatic pulse();
        periph_req <= 1'b1;
        repeat (4) @(posedge pclk);
        periph_req <= 1'b0;
        repeat (16) @(posedge pclk);
    endtask : pulse
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #100us;
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc("len reset", LEN_IDX, 0);
        rc("ctrl reset", CTRL_IDX, 0);
        rc("index reset", ITEM_IDX, 0);
        rc("unmapped", 32'h0000_0100, 0);
        chk("unmapped err", 1, e);
        apb(1'b1, CTRL_IDX, 32'h0000_C000);
        rc("ctrl read-only", CTRL_IDX, 0);
        for (int w = 0; w < 3; w++) begin
            setup(1);
            c = '0;
            c.item_width = w[1:0];
            c.dest_step_enable = 1'b1;
            c.on = 1'b1;
            go(c, 1);
            chk("writes", 2, mem.wr_n - n0);
            chk("dst step", 32'h2000 + (1 << w), mem.wr_a[n0 + 1]);
            chk("src hold", 32'h1000, mem.rd_a[m0 + 1]);
        end
        setup(2);
        c.item_width = W_WORD;
        c.source_step_enable = 1'b1;
        c.yield = 1'b1;
        slow <= 1'b1;
        go(c, 1);
        slow <= 1'b0;
        chk("writes", 3, mem.wr_n - n0);
        chk("src step", 32'h1008, mem.rd_a[m0 + 2]);
        chk("dst word", 32'h2008, mem.wr_a[n0 + 2]);
        rc("index done", ITEM_IDX, 0);
        setup(3);
        c = '0;
        c.fill = 1'b1;
        c.dest_step_enable = 1'b1;
        c.item_width = W_WORD;
        c.on = 1'b1;
        go(c, 1);
        chk("fill reads", 1, mem.rd_n - m0);
        chk("fill writes", 4, mem.wr_n - n0);
        chk("fill data", mem.pat(32'h1000), mem.wr_d[n0 + 3]);
        chk("fill step", 32'h200C, mem.wr_a[n0 + 3]);
        apb(1'b1, THR_IDX, 1);
        apb(1'b1, MASK_IDX, 3);
        setup(2);
        c.fill = 1'b0;
        c.irq_en = 1'b1;
        go(c, 1);
        chk("irq set", 1, irq);
        rc("status", STAT_IDX, 3);
        apb(1'b1, STAT_IDX, 3);
        rc("status clear", STAT_IDX, 0);
        chk("irq clear", 0, irq);
        apb(1'b1, MASK_IDX, 0);
        go(c, 1);
        chk("irq masked", 0, irq);
        apb(1'b1, STAT_IDX, 3);
        apb(1'b1, MASK_IDX, 3);
        c.irq_en = 1'b0;
        go(c, 1);
        rc("no event", STAT_IDX, 0);
        chk("irq gated", 0, irq);
        setup(0);
        c.channel_priority = 3'h3;
        zero_arb <= '{req: 1'b1, prio: 3'h3};
        apb(1'b1, CTRL_IDX, {16'h0, c});
        repeat (20) @(posedge pclk);
        chk("equal prio", 0, mem.rd_n - m0);
        zero_arb <= '{req: 1'b1, prio: 3'h2};
        go(c, 0);
        zero_arb <= '0;
        setup(1);
        c.request_trigger_mode = 1'b1;
        apb(1'b1, CTRL_IDX, {16'h0, c});
        repeat (20) @(posedge pclk);
        chk("no request", 0, mem.rd_n - m0);
        periph_req <= 1'b1;
        go(c, 0);
        periph_req <= 1'b0;
        chk("level writes", 2, mem.wr_n - n0);
        setup(1);
        c.edge_sense = 1'b1;
        c.circular = 1'b1;
        apb(1'b1, CTRL_IDX, {16'h0, c});
        pulse();
        chk("edge item", 1, mem.wr_n - n0);
        pulse();
        pulse();
        chk("circ writes", 3, mem.wr_n - n0);
        chk("circ restart", 32'h2000, mem.wr_a[n0 + 2]);
        rc("circ on", CTRL_IDX, {16'h0, c});
        apb(1'b1, CTRL_IDX, 0);
        report_and_stop();
    end
endmodule : tb
bind dma_channel_control dma_channel_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .mem_req, .mem_ack, .mem_rdata, .zero_arb, .one_arb, .bus_lock,
    .irq);
